// File: nand_opcode_pkg.sv
// Opcode classes, interface modes and timing constants for the target
// command decoder. Assumes a 250 MHz system clock.
package nand_opcode_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS          = 4;
	localparam int WRITE_TO_BUSY_DELAY_NS = 100;
	localparam int WRITE_TO_BUSY_CYCLES   =
		(WRITE_TO_BUSY_DELAY_NS / CLK_PERIOD_NS) > 1 ?
		(WRITE_TO_BUSY_DELAY_NS / CLK_PERIOD_NS) : 1;
	localparam int RESET_BUSY_NS          = 5000;
	localparam int RESET_BUSY_CYCLES      = RESET_BUSY_NS / CLK_PERIOD_NS;
	localparam int CNT_W                  = 16;

	// Opcodes
	localparam logic [7:0] OP_PROGRAM        = 8'h80;
	localparam logic [7:0] OP_COPYBACK       = 8'h85;
	localparam logic [7:0] OP_CONFIRM_COMMIT = 8'h10;
	localparam logic [7:0] OP_READ_PARAM     = 8'hec;
	localparam logic [7:0] OP_READ_UID       = 8'hed;
	localparam logic [7:0] OP_GET_FEAT       = 8'hee;
	localparam logic [7:0] OP_SET_FEAT       = 8'hef;
	localparam logic [7:0] OP_DUTY_TRAIN     = 8'h18;
	localparam logic [7:0] OP_READ_DQ_TRAIN  = 8'h62;
	localparam logic [7:0] OP_TX_TRAIN_PAT   = 8'h63;
	localparam logic [7:0] OP_TX_TRAIN_RB    = 8'h64;
	localparam logic [7:0] OP_RX_TRAIN       = 8'h76;
	localparam logic [7:0] OP_LUN_GET_FEAT   = 8'hd4;
	localparam logic [7:0] OP_LUN_SET_FEAT   = 8'hd5;
	localparam logic [7:0] OP_CAL_SHORT      = 8'hd9;
	localparam logic [7:0] OP_CAL_LONG       = 8'hf9;
	localparam logic [7:0] OP_RESET_LUN      = 8'hfa;
	localparam logic [7:0] OP_SYNC_RESET     = 8'hfc;
	localparam logic [7:0] OP_RESET          = 8'hff;
	localparam logic [7:0] OP_VOLUME_SELECT  = 8'he1;
	localparam logic [7:0] OP_TERM_CONFIG    = 8'he2;

	typedef enum logic [1:0] {
		IF_SINGLE_RATE,
		IF_DOUBLE_RATE_V1,
		IF_DOUBLE_RATE_V2,
		IF_DOUBLE_RATE_V3
	} iface_e;

	typedef enum logic [1:0] {
		CLS_STANDARD,
		CLS_VENDOR,
		CLS_RESERVED
	} opclass_e;

	typedef enum logic [4:0] {
		CMD_NONE,
		CMD_READ_PARAM,
		CMD_READ_UID,
		CMD_GET_FEAT,
		CMD_SET_FEAT,
		CMD_DUTY_TRAIN,
		CMD_READ_DQ_TRAIN,
		CMD_TX_TRAIN_PAT,
		CMD_TX_TRAIN_RB,
		CMD_RX_TRAIN,
		CMD_LUN_GET_FEAT,
		CMD_LUN_SET_FEAT,
		CMD_CAL_SHORT,
		CMD_CAL_LONG,
		CMD_RESET_LUN,
		CMD_SYNC_RESET,
		CMD_RESET,
		CMD_PROGRAM_START,
		CMD_COPYBACK_START,
		CMD_COMMIT,
		CMD_VOLUME_SELECT,
		CMD_TERM_CONFIG,
		CMD_VENDOR
	} cmd_e;

	// Decoded result of one command cycle
	typedef struct packed {
		logic     valid;
		cmd_e     cmd;
		opclass_e cls;
		logic     targetLevel;
		logic     okOtherBusy;
		logic     okSelfBusy;
	} decode_s;

	// Feature settings: retained ones survive a full reset
	typedef struct packed {
		logic [7:0] retained;
		logic [7:0] volatileSet;
		logic       termEnable;
	} feat_s;

	localparam logic [7:0] FEAT_RESET_VAL = 8'h00;

endpackage

// File: nand_opcode_classify.sv
// Pure opcode classifier: standard, vendor and reserved opcode classes.
// Assumes the opcode is stable while cmdValid is high.
`timescale 1ns/1ps
module nand_opcode_classify (
	// Command cycle
	input  wire logic                    cmdValid,
	input  wire logic [7:0]              opcode,
	input  wire logic                    volSelSupport,
	input  wire logic                    termSupport,
	// Result
	output nand_opcode_pkg::decode_s     dec
);

	function automatic logic isReserved(input logic [7:0] op);
		case (op)
			8'h0b, 8'h12, 8'h14, 8'h1b, 8'h1c,
			8'h82, 8'h83, 8'h86, 8'h8e: isReserved = 1'b1;
			default: isReserved = 1'b0;
		endcase
	endfunction

	function automatic logic isStandard(input logic [7:0] op);
		case (op)
			8'h00, 8'h05, 8'h06, 8'h10, 8'h11, 8'h15, 8'h18, 8'h30,
			8'h31, 8'h32, 8'h35, 8'h3f, 8'h60, 8'h62, 8'h63, 8'h64,
			8'h70, 8'h76, 8'h78, 8'h80, 8'h81, 8'h85, 8'h90, 8'hd0,
			8'hd1, 8'hd4, 8'hd5, 8'hd9, 8'he0, 8'he1, 8'he2, 8'hec,
			8'hed, 8'hee, 8'hef, 8'hf1, 8'hf2, 8'hf9, 8'hfa, 8'hfc,
			8'hff: isStandard = 1'b1;
			default: isStandard = 1'b0;
		endcase
	endfunction

	always_comb begin
		dec = '0;
		dec.cmd = nand_opcode_pkg::CMD_NONE;
		if (isReserved(opcode)) begin
			dec.cls = nand_opcode_pkg::CLS_RESERVED;
		end else if (isStandard(opcode)) begin
			dec.cls = nand_opcode_pkg::CLS_STANDARD;
		end else begin
			dec.cls = nand_opcode_pkg::CLS_VENDOR;
		end
		case (opcode)
			nand_opcode_pkg::OP_READ_PARAM: begin
				dec.cmd = nand_opcode_pkg::CMD_READ_PARAM;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_READ_UID: begin
				dec.cmd = nand_opcode_pkg::CMD_READ_UID;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_GET_FEAT: begin
				dec.cmd = nand_opcode_pkg::CMD_GET_FEAT;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_SET_FEAT: begin
				dec.cmd = nand_opcode_pkg::CMD_SET_FEAT;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_LUN_GET_FEAT: begin
				dec.cmd = nand_opcode_pkg::CMD_LUN_GET_FEAT;
				dec.okOtherBusy = 1'b1;
			end
			nand_opcode_pkg::OP_LUN_SET_FEAT: begin
				dec.cmd = nand_opcode_pkg::CMD_LUN_SET_FEAT;
				dec.okOtherBusy = 1'b1;
			end
			nand_opcode_pkg::OP_CAL_SHORT: begin
				dec.cmd = nand_opcode_pkg::CMD_CAL_SHORT;
				dec.okOtherBusy = 1'b1;
			end
			nand_opcode_pkg::OP_CAL_LONG: begin
				dec.cmd = nand_opcode_pkg::CMD_CAL_LONG;
				dec.okOtherBusy = 1'b1;
			end
			nand_opcode_pkg::OP_READ_DQ_TRAIN:
				dec.cmd = nand_opcode_pkg::CMD_READ_DQ_TRAIN;
			nand_opcode_pkg::OP_TX_TRAIN_PAT:
				dec.cmd = nand_opcode_pkg::CMD_TX_TRAIN_PAT;
			nand_opcode_pkg::OP_TX_TRAIN_RB:
				dec.cmd = nand_opcode_pkg::CMD_TX_TRAIN_RB;
			nand_opcode_pkg::OP_RX_TRAIN:
				dec.cmd = nand_opcode_pkg::CMD_RX_TRAIN;
			nand_opcode_pkg::OP_DUTY_TRAIN:
				dec.cmd = nand_opcode_pkg::CMD_DUTY_TRAIN;
			nand_opcode_pkg::OP_RESET_LUN: begin
				dec.cmd = nand_opcode_pkg::CMD_RESET_LUN;
				dec.okOtherBusy = 1'b1;
				dec.okSelfBusy = 1'b1;
			end
			nand_opcode_pkg::OP_SYNC_RESET: begin
				dec.cmd = nand_opcode_pkg::CMD_SYNC_RESET;
				dec.okOtherBusy = 1'b1;
				dec.okSelfBusy = 1'b1;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_RESET: begin
				dec.cmd = nand_opcode_pkg::CMD_RESET;
				dec.okOtherBusy = 1'b1;
				dec.okSelfBusy = 1'b1;
				dec.targetLevel = 1'b1;
			end
			nand_opcode_pkg::OP_PROGRAM:
				dec.cmd = nand_opcode_pkg::CMD_PROGRAM_START;
			nand_opcode_pkg::OP_COPYBACK:
				dec.cmd = nand_opcode_pkg::CMD_COPYBACK_START;
			nand_opcode_pkg::OP_CONFIRM_COMMIT:
				dec.cmd = nand_opcode_pkg::CMD_COMMIT;
			nand_opcode_pkg::OP_VOLUME_SELECT:
				if (volSelSupport) begin
					dec.cmd = nand_opcode_pkg::CMD_VOLUME_SELECT;
				end
			nand_opcode_pkg::OP_TERM_CONFIG:
				if (termSupport) begin
					dec.cmd = nand_opcode_pkg::CMD_TERM_CONFIG;
				end
			default:
				if (dec.cls == nand_opcode_pkg::CLS_VENDOR) begin
					dec.cmd = nand_opcode_pkg::CMD_VENDOR;
				end
		endcase
		// Reserved or unimplemented opcodes yield no valid decode
		dec.valid = cmdValid && (dec.cmd != nand_opcode_pkg::CMD_NONE)
			&& (dec.cls != nand_opcode_pkg::CLS_RESERVED);
	end

endmodule

// File: nand_target_opcode_decode_reset.sv
// Target command-cycle decoder with full-reset sequencing.
// Outputs are registered; strobes stand one cycle.
// Busy length is a parameter so benches can shorten it.
// Limitation: busy length is fixed, not tied to the array.
// Assumes command cycles arrive as one-cycle latch pulses synchronous to
// clk_sys; the bus timing front end sits outside this block.
`timescale 1ns/1ps

module nand_target_opcode_decode_reset #(
	parameter int RESET_BUSY = nand_opcode_pkg::RESET_BUSY_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	// Command and address cycles from the bus front end
	input  wire logic                 cmdLatch,
	input  wire logic                 addrLatch,
	input  wire logic [7:0]           busByte,
	input  wire logic                 addrHasRow,
	// Bus idle state and data strobe
	input  wire logic                 busIdle,
	input  wire logic                 dataStrobe,
	// Capabilities and status from the array side
	input  wire logic                 volSelSupport,
	input  wire logic                 termSupport,
	input  wire logic                 accessedLunBusy,
	input  wire logic                 otherLunBusy,
	// Feature writes
	input  wire logic                 featWrite,
	input  wire logic                 featRetainSel,
	input  wire logic [7:0]           featData,
	input  wire nand_opcode_pkg::iface_e featIface,
	// Decoded command out
	output nand_opcode_pkg::cmd_e     cmdOut,
	output logic                      cmdStrobe,
	output logic                      needSecond,
	output logic                      commitStrobe,
	output logic                      addrColOnly,
	// Reset and status
	output logic                      lunResetAll,
	output logic                      readyBusy,
	output nand_opcode_pkg::iface_e   ifaceMode,
	output nand_opcode_pkg::feat_s    features,
	output logic                      termActive,
	output logic                      addrError
);

	// ********
	// State
	// ********
	// One packed struct holds every flop; one always_ff
	// registers it and the comb block edits a copy.
	// States: single commands, pair wait, reset busy.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_SECOND,
		ST_RESET_BUSY
	} state_e;

	// cnt times the busy stretch; smallMove marks an open
	// 80h or 85h pair that only its own 10h may commit.
	// cmd holds the last accepted command.
	typedef struct packed {
		state_e                     st;
		nand_opcode_pkg::cmd_e      cmd;
		logic                       strobe;
		logic                       second;
		logic                       commit;
		logic                       colOnly;
		logic                       smallMove;
		logic                       lunReset;
		logic                       rdy;
		logic [nand_opcode_pkg::CNT_W-1:0] cnt;
		nand_opcode_pkg::iface_e    iface;
		nand_opcode_pkg::feat_s     feat;
		logic                       term;
		logic                       addrErr;
	} regs_s;

	regs_s st_ff;
	regs_s nxt_st;
	nand_opcode_pkg::decode_s dec;
	logic  fullReset;

	// ********
	// Opcode classification
	// ********
	// Purely combinational; it only counts while cmdLatch
	// is high. Straps gate E1h and E2h in there.
	nand_opcode_classify u_classify (
		.cmdValid      (cmdLatch),
		.opcode        (busByte),
		.volSelSupport (volSelSupport),
		.termSupport   (termSupport),
		.dec           (dec)
	);

	// FFh bypasses busy gating and the pair wait
	assign fullReset = dec.valid
		&& (dec.cmd == nand_opcode_pkg::CMD_RESET);

	// ********
	// Busy gating
	// ********
	// Per-LUN commands never wait on other LUNs; only
	// target-level ones do. FFh never reaches this.
	function automatic logic busyOk(input nand_opcode_pkg::decode_s d,
		input logic selfBusy, input logic otherBusy);
		logic selfOk;
		logic otherOk;
		selfOk  = !selfBusy || d.okSelfBusy;
		otherOk = !otherBusy || d.okOtherBusy || !d.targetLevel;
		busyOk  = selfOk && otherOk;
	endfunction

	// ********
	// Next-state logic
	// ********
	// Pulses default low, so no strobe stands two cycles.
	// Priority: full reset, then the state machine.
	always_comb begin
		nxt_st          = st_ff;
		nxt_st.strobe   = 1'b0;
		nxt_st.commit   = 1'b0;
		nxt_st.lunReset = 1'b0;
		nxt_st.addrErr  = 1'b0;

		// Termination only follows the inverted strobe when enabled and
		// on an idle bus, so data cycles see no false enable.
		if (st_ff.feat.termEnable && busIdle) begin
			nxt_st.term = !dataStrobe;
		end else begin
			nxt_st.term = 1'b0;
		end

		// Change write/row address form check on address cycles;
		// a row address clears addrColOnly.
		if (addrLatch && st_ff.st == ST_WAIT_SECOND) begin
			nxt_st.colOnly = !addrHasRow;
		end

		// Writes are dropped during reset busy so the restored defaults
		// stay whole; bit 0 is the termination enable.
		if (featWrite && st_ff.st != ST_RESET_BUSY) begin
			if (featRetainSel) begin
				nxt_st.feat.retained = featData;
			end else begin
				nxt_st.feat.volatileSet = featData;
				nxt_st.feat.termEnable  = featData[0];
			end
			nxt_st.iface = featIface;
		end

		// Full reset wins over any state, including a busy array
		if (fullReset) begin
			nxt_st.st       = ST_RESET_BUSY;
			nxt_st.cmd      = dec.cmd;
			nxt_st.strobe   = 1'b1;
			nxt_st.second   = 1'b0;
			nxt_st.lunReset = 1'b1;
			nxt_st.rdy      = 1'b0;
			// A second FFh while busy restarts a full stretch
			nxt_st.cnt      = '0;
			nxt_st.smallMove = 1'b0;
			// Volatile features return to power-up values
			nxt_st.feat.volatileSet = nand_opcode_pkg::FEAT_RESET_VAL;
			nxt_st.feat.termEnable  = 1'b0;
			// Retained field is left untouched
			nxt_st.feat.retained = st_ff.feat.retained;
			// v1 and v2 drop to single rate; v3 is kept so
			// a host at v3 keeps its link across reset.
			if (st_ff.iface == nand_opcode_pkg::IF_DOUBLE_RATE_V3) begin
				nxt_st.iface = nand_opcode_pkg::IF_DOUBLE_RATE_V3;
			end else begin
				nxt_st.iface = nand_opcode_pkg::IF_SINGLE_RATE;
			end
		end else begin
			// Normal decoding, one state at a time
			case (st_ff.st)
				ST_IDLE: begin
					// Refused opcodes are dropped; nothing changes
					if (dec.valid && busyOk(dec, accessedLunBusy,
						otherLunBusy)) begin
						nxt_st.cmd    = dec.cmd;
						nxt_st.strobe = 1'b1;
						if (dec.cmd == nand_opcode_pkg::CMD_PROGRAM_START ||
							dec.cmd == nand_opcode_pkg::CMD_COPYBACK_START)
						begin
							// 80h or 85h opens the small move pair
							nxt_st.st        = ST_WAIT_SECOND;
							nxt_st.second    = 1'b1;
							nxt_st.smallMove = 1'b1;
							nxt_st.colOnly   = 1'b1;
						end
						// FCh and FAh only pulse the LUN reset
						if (dec.cmd == nand_opcode_pkg::CMD_SYNC_RESET ||
							dec.cmd == nand_opcode_pkg::CMD_RESET_LUN) begin
							nxt_st.lunReset = 1'b1;
						end
					end
					// Anything else leaves state and ready/busy alone
				end
				ST_WAIT_SECOND: begin
					// Only 10h closes the pair; 85h re-entry edits
					// the address form; others are flagged.
					if (dec.valid) begin
						if (dec.cmd == nand_opcode_pkg::CMD_COMMIT &&
							st_ff.smallMove) begin
							nxt_st.commit    = 1'b1;
							nxt_st.cmd       = dec.cmd;
							nxt_st.strobe    = 1'b1;
							nxt_st.st        = ST_IDLE;
							nxt_st.second    = 1'b0;
							nxt_st.smallMove = 1'b0;
						end else if (dec.cmd ==
							nand_opcode_pkg::CMD_COPYBACK_START) begin
							// Change write column / row address re-entry
							nxt_st.colOnly = 1'b1;
						end else begin
							nxt_st.addrErr = 1'b1;
						end
					end
				end
				ST_RESET_BUSY: begin
					// Compare ends one short: busy stands
					// exactly RESET_BUSY cycles.
					if (st_ff.cnt >= nand_opcode_pkg::CNT_W'(RESET_BUSY - 1))
					begin
						nxt_st.st  = ST_IDLE;
						nxt_st.rdy = 1'b1;
						nxt_st.cnt = '0;
					end else begin
						nxt_st.cnt = st_ff.cnt + 1'b1;
					end
				end
				default: begin
					// Unused encoding: back to idle, no lock-up
					nxt_st.st = ST_IDLE;
				end
			endcase
		end
	end

	// ********
	// State register
	// ********
	// Reset: ready high, single rate, no command seen
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff      <= '0;
			st_ff.st   <= ST_IDLE;
			st_ff.cmd  <= nand_opcode_pkg::CMD_NONE;
			st_ff.rdy  <= 1'b1;
			st_ff.iface <= nand_opcode_pkg::IF_SINGLE_RATE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ********
	// Outputs
	// ********
	// Every output comes straight from a flop.
	// ifaceMode picks the front end's timing set.
	assign cmdOut       = st_ff.cmd;
	assign cmdStrobe    = st_ff.strobe;
	assign needSecond   = st_ff.second;
	assign commitStrobe = st_ff.commit;
	assign addrColOnly  = st_ff.colOnly;
	assign lunResetAll  = st_ff.lunReset;
	assign readyBusy    = st_ff.rdy;
	assign ifaceMode    = st_ff.iface;
	assign features     = st_ff.feat;
	assign termActive   = st_ff.term;
	assign addrError    = st_ff.addrErr;

endmodule

// File: nand_opcode_chk.sv
// Property checker for the target command decoder.
// Assumes one clock domain and one-cycle answers.
`timescale 1ns/1ps
module nand_opcode_chk #(
	parameter int RESET_BUSY = 8
) (
	// Clock and reset
	input wire logic                    clk_sys,
	input wire logic                    nrst,
	// Inputs watched
	input wire logic                    cmdLatch,
	input wire logic [7:0]              busByte,
	input wire logic                    otherLunBusy,
	input wire logic                    featWrite,
	// Outputs watched
	input wire logic                    cmdStrobe,
	input wire nand_opcode_pkg::cmd_e   cmdOut,
	input wire logic                    commitStrobe,
	input wire logic                    lunResetAll,
	input wire logic                    readyBusy,
	input wire nand_opcode_pkg::iface_e ifaceMode,
	input wire nand_opcode_pkg::feat_s  features,
	input wire logic                    termActive
);
	// ********
	// Helpers
	// ********
	logic [15:0] busyCnt_ff;
	logic [15:0] nxt_busyCnt;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence sCmd(logic [7:0] op);
		cmdLatch && busByte == op;
	endsequence

	// A repeated reset restarts the busy stretch
	always_comb begin
		nxt_busyCnt = busyCnt_ff + 16'h0001;
		if (readyBusy || (cmdLatch && busByte == 8'hff))
			nxt_busyCnt = 16'h0000;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			busyCnt_ff <= 16'h0000;
		else
			busyCnt_ff <= nxt_busyCnt;
	end

	// ********
	// Rules
	// ********
	a_reset_taken: assert property (
		sCmd(8'hff) |=> cmdStrobe && lunResetAll && !readyBusy &&
		cmdOut == nand_opcode_pkg::CMD_RESET)
		else $error("full reset not taken");
	a_reserved_dropped: assert property (
		cmdLatch && busByte inside {8'h0b, 8'h12, 8'h14, 8'h1b, 8'h1c,
		8'h82, 8'h83, 8'h86, 8'h8e} |=> !cmdStrobe && $stable(cmdOut))
		else $error("reserved opcode acted on");
	a_vendor_only: assert property (
		(sCmd(8'h84) or sCmd(8'hf0)) |=> !cmdStrobe ||
		cmdOut == nand_opcode_pkg::CMD_VENDOR)
		else $error("vendor opcode given standard meaning");
	a_target_blocked: assert property (
		cmdLatch && otherLunBusy &&
		busByte inside {8'hec, 8'hed, 8'hee, 8'hef} |=> !cmdStrobe)
		else $error("target command taken while other lun busy");
	a_commit_cause: assert property (
		commitStrobe |-> $past(cmdLatch) && $past(busByte) == 8'h10)
		else $error("commit without confirm opcode");
	a_lun_reset_cause: assert property (
		lunResetAll |-> $past(cmdLatch) &&
		$past(busByte) inside {8'hfa, 8'hfc, 8'hff})
		else $error("lun reset without reset opcode");
	a_busy_bounded: assert property (
		!readyBusy |-> busyCnt_ff < RESET_BUSY)
		else $error("busy stretch too long");
	a_iface_fallback: assert property (
		sCmd(8'hff) ##0 (!featWrite &&
		ifaceMode != nand_opcode_pkg::IF_DOUBLE_RATE_V3)
		|=> ifaceMode == nand_opcode_pkg::IF_SINGLE_RATE)
		else $error("reset did not fall back to single rate");
	a_iface_keep: assert property (
		sCmd(8'hff) ##0 ifaceMode == nand_opcode_pkg::IF_DOUBLE_RATE_V3
		|=> ifaceMode == nand_opcode_pkg::IF_DOUBLE_RATE_V3)
		else $error("reset left rate v3");
	a_retained_kept: assert property (
		sCmd(8'hff) ##0 !featWrite |=> $stable(features.retained) &&
		features.volatileSet == 8'h00)
		else $error("reset lost retained features");
	a_term_ignored: assert property (
		(!features.termEnable) [*2] |-> !termActive)
		else $error("termination active while disabled");
endmodule

bind nand_target_opcode_decode_reset nand_opcode_chk #(
	.RESET_BUSY(RESET_BUSY)
) i_chk (
	.clk_sys, .nrst, .cmdLatch, .busByte, .otherLunBusy, .featWrite,
	.cmdStrobe, .cmdOut, .commitStrobe, .lunResetAll, .readyBusy,
	.ifaceMode, .features, .termActive
);

// File: host_cmd_model.sv
// Host model that turns bench requests into latch cycles.
// Assumes the target samples latch pulses on the rising edge.
`timescale 1ns/1ps
module host_cmd_model (
	// Clock and status
	input  wire logic  clk_sys,
	input  wire logic  readyBusy,
	// Bus toward the target
	output logic       cmdLatch,
	output logic       addrLatch,
	output logic [7:0] busByte,
	output logic       addrHasRow,
	output logic       busIdle,
	output logic       dataStrobe
);
	int   idleGap   = 0;
	logic seenReady = 1'b0;

	initial begin
		cmdLatch = 1'b0;
		addrLatch = 1'b0;
		busByte = 8'h00;
		addrHasRow = 1'b0;
		busIdle = 1'b1;
		dataStrobe = 1'b1;
	end

	// One command or address cycle, then back to idle
	task automatic cycle(input logic isCmd, input logic [7:0] b,
		input logic row);
		if (!seenReady)
			wait (readyBusy);
		seenReady = 1'b1;
		repeat (idleGap) @(posedge clk_sys);
		@(posedge clk_sys);
		cmdLatch <= isCmd;
		addrLatch <= !isCmd;
		busByte <= b;
		addrHasRow <= row;
		busIdle <= 1'b0;
		@(posedge clk_sys);
		cmdLatch <= 1'b0;
		addrLatch <= 1'b0;
		// A released bus must not look like the last byte
		busByte <= ~b;
		busIdle <= 1'b1;
	endtask

	// Drives the idle strobe to lvl on purpose to probe termination
	task automatic strobe(input logic lvl);
		@(posedge clk_sys);
		dataStrobe <= lvl;
	endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the target command decoder.
// Assumes the host model drives the bus, the bench the array side.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
	localparam int RB = 8;

	logic                    clk_sys, nrst, cmdLatch, addrLatch, addrHasRow;
	logic                    busIdle, dataStrobe, volSelSupport, termSupport;
	logic                    accessedLunBusy, otherLunBusy, featWrite;
	logic                    featRetainSel, cmdStrobe, needSecond;
	logic                    commitStrobe, addrColOnly, lunResetAll;
	logic                    readyBusy, termActive, addrError;
	logic [7:0]              busByte, featData;
	nand_opcode_pkg::iface_e featIface, ifaceMode;
	nand_opcode_pkg::cmd_e   cmdOut;
	nand_opcode_pkg::feat_s  features;
	int                      err_total = 0;
	int                      cmp_count = 0;

	nand_target_opcode_decode_reset #(.RESET_BUSY(RB)) i_dut (
		.clk_sys, .nrst, .cmdLatch, .addrLatch, .busByte, .addrHasRow,
		.busIdle, .dataStrobe, .volSelSupport, .termSupport,
		.accessedLunBusy, .otherLunBusy, .featWrite, .featRetainSel,
		.featData, .featIface, .cmdOut, .cmdStrobe, .needSecond,
		.commitStrobe, .addrColOnly, .lunResetAll, .readyBusy, .ifaceMode,
		.features, .termActive, .addrError
	);
	host_cmd_model i_host (
		.clk_sys, .readyBusy, .cmdLatch, .addrLatch, .busByte, .addrHasRow,
		.busIdle, .dataStrobe
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ********
	// Helpers
	// ********
	task automatic send(input logic [7:0] op);
		i_host.cycle(1'b1, op, 1'b0);
		@(negedge clk_sys);
	endtask

	task automatic feat(input logic r, input logic [7:0] d,
		input nand_opcode_pkg::iface_e m);
		@(posedge clk_sys);
		featWrite <= 1'b1;
		featRetainSel <= r;
		featData <= d;
		featIface <= m;
		@(posedge clk_sys);
		featWrite <= 1'b0;
	endtask

	task automatic print_verdict;
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_decode;
		logic [7:0] ops [19] = '{8'hec, 8'hed, 8'hee, 8'hef, 8'h18, 8'h62,
			8'h63, 8'h64, 8'h76, 8'hd4, 8'hd5, 8'hd9, 8'hf9, 8'hfa, 8'hfc,
			8'he1, 8'he2, 8'h84, 8'hf0};
		logic [4:0] exc [19] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7,
			5'd8, 5'd9, 5'd10, 5'd11, 5'd12, 5'd13, 5'd14, 5'd15, 5'd20,
			5'd21, 5'd22, 5'd22};
		for (int i = 0; i < 19; i++) begin
			send(ops[i]);
			`CHK(cmdStrobe, 1'b1)
			`CHK(cmdOut, exc[i])
		end
		@(posedge clk_sys);
		termSupport <= 1'b0;
		send(8'he2);
		`CHK(cmdStrobe, 1'b0)
		@(posedge clk_sys);
		termSupport <= 1'b1;
	endtask

	task automatic t_reserved;
		logic [7:0] rsv [9] = '{8'h0b, 8'h12, 8'h14, 8'h1b, 8'h1c, 8'h82,
			8'h83, 8'h86, 8'h8e};
		for (int i = 0; i < 9; i++) begin
			send(rsv[i]);
			`CHK(cmdStrobe, 1'b0)
			`CHK({cmdOut, readyBusy}, {5'd22, 1'b1})
		end
	endtask

	task automatic t_busy;
		i_host.idleGap = 2;
		@(posedge clk_sys);
		otherLunBusy <= 1'b1;
		send(8'hd5);
		`CHK(cmdStrobe, 1'b1)
		send(8'hee);
		`CHK(cmdStrobe, 1'b0)
		send(8'hf9);
		`CHK(cmdStrobe, 1'b1)
		@(posedge clk_sys);
		accessedLunBusy <= 1'b1;
		send(8'hfa);
		`CHK(lunResetAll, 1'b1)
		send(8'hfc);
		`CHK({lunResetAll, readyBusy}, 2'b11)
		send(8'h63);
		`CHK(cmdStrobe, 1'b0)
		@(posedge clk_sys);
		accessedLunBusy <= 1'b0;
		otherLunBusy <= 1'b0;
		i_host.idleGap = 0;
	endtask

	task automatic t_program;
		send(8'h80);
		`CHK(needSecond, 1'b1)
		i_host.cycle(1'b0, 8'h00, 1'b1);
		@(negedge clk_sys);
		`CHK(addrColOnly, 1'b0)
		send(8'h10);
		`CHK({commitStrobe, needSecond}, 2'b10)
		send(8'h85);
		i_host.cycle(1'b0, 8'h04, 1'b0);
		@(negedge clk_sys);
		`CHK(addrColOnly, 1'b1)
		send(8'hed);
		`CHK(addrError, 1'b1)
		send(8'h10);
	endtask

	task automatic t_reset;
		feat(1'b1, 8'ha5, nand_opcode_pkg::IF_DOUBLE_RATE_V1);
		feat(1'b0, 8'h01, nand_opcode_pkg::IF_DOUBLE_RATE_V1);
		send(8'hff);
		`CHK({readyBusy, lunResetAll}, 2'b01)
		`CHK(ifaceMode, nand_opcode_pkg::IF_SINGLE_RATE)
		`CHK(features, {8'ha5, 8'h00, 1'b0})
		repeat (RB - 1) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(readyBusy, 1'b0)
		@(negedge clk_sys);
		`CHK(readyBusy, 1'b1)
		feat(1'b1, 8'h3c, nand_opcode_pkg::IF_DOUBLE_RATE_V3);
		@(posedge clk_sys);
		accessedLunBusy <= 1'b1;
		otherLunBusy <= 1'b1;
		send(8'hff);
		send(8'hff);
		`CHK(cmdStrobe, 1'b1)
		`CHK(ifaceMode, nand_opcode_pkg::IF_DOUBLE_RATE_V3)
		@(posedge clk_sys);
		accessedLunBusy <= 1'b0;
		otherLunBusy <= 1'b0;
		repeat (RB) @(negedge clk_sys);
		`CHK(readyBusy, 1'b1)
	endtask

	task automatic t_term;
		i_host.strobe(1'b0);
		repeat (3) @(negedge clk_sys);
		`CHK(termActive, 1'b0)
		feat(1'b0, 8'h01, nand_opcode_pkg::IF_SINGLE_RATE);
		repeat (3) @(negedge clk_sys);
		`CHK(termActive, 1'b1)
		i_host.strobe(1'b1);
		repeat (3) @(negedge clk_sys);
		`CHK(termActive, 1'b0)
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		volSelSupport = 1'b1;
		termSupport = 1'b1;
		accessedLunBusy = 1'b0;
		otherLunBusy = 1'b0;
		featWrite = 1'b0;
		featRetainSel = 1'b0;
		featData = 8'h00;
		featIface = nand_opcode_pkg::IF_SINGLE_RATE;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		t_decode();
		t_reserved();
		t_busy();
		t_program();
		t_reset();
		t_term();
		print_verdict();
	end
endmodule
